// [acr_pkg.sv]
`default_nettype none
// ==========================================================================
// Shared constants and types for the receive clock and data recovery.
// ==========================================================================
package acr_pkg;

	// ======================================================================
	// Sample counting.
	// ======================================================================
	localparam int CNT_W = 5;
	localparam logic [4:0] SPB_NORMAL = 5'h10;
	localparam logic [4:0] SPB_DOUBLE = 5'h08;
	localparam logic [4:0] SAMPLE_FIRST = 5'h01;
	localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
	localparam logic [4:0] VOTE_LAST_NORMAL = 5'h0A;
	localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
	localparam logic [4:0] VOTE_LAST_DOUBLE = 5'h06;

	// ======================================================================
	// Character format and received word layout.
	// ======================================================================
	localparam int DATA_W = 9;
	localparam int IDX_W = 4;
	localparam logic [3:0] CHAR_MIN = 4'h5;
	localparam logic [3:0] CHAR_MAX = 4'h9;
	localparam int WORD_W = 11;
	localparam int WORD_PARITY = 9;
	localparam int WORD_FERR = 10;
	localparam int BUF_DEPTH = 2;

	// ======================================================================
	// Recovery states.
	// ======================================================================
	typedef enum logic [1:0] {
		ACR_IDLE,
		ACR_START,
		ACR_DATA,
		ACR_STOP
	} acr_st_type;

	// Samples per bit for the selected speed.
	function automatic logic [4:0] samples_per_bit(input logic ds);
		return ds ? SPB_DOUBLE : SPB_NORMAL;
	endfunction : samples_per_bit

	// True for the three centre samples of a bit.
	function automatic logic in_vote(input logic [4:0] cnt, input logic ds);
		if (ds) begin
			return (cnt >= VOTE_FIRST_DOUBLE) && (cnt <= VOTE_LAST_DOUBLE);
		end
		return (cnt >= VOTE_FIRST_NORMAL) && (cnt <= VOTE_LAST_NORMAL);
	endfunction : in_vote

	// True for the last centre sample, where the vote is taken.
	function automatic logic vote_last(input logic [4:0] cnt, input logic ds);
		return cnt == (ds ? VOTE_LAST_DOUBLE : VOTE_LAST_NORMAL);
	endfunction : vote_last

	// Two or three high samples give a high result.
	function automatic logic maj3(input logic [2:0] v);
		return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction : maj3

endpackage : acr_pkg
`default_nettype wire

// [acr_sync.sv]
`default_nettype none
// ==========================================================================
// Three-stage input synchroniser with agreement filter.
// ==========================================================================
module acr_sync (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Asynchronous pin and its filtered level.
	input wire logic pin_in,
	output logic level_out
);

	typedef struct packed {
		logic ff1;
		logic ff2;
		logic ff3;
		logic level;
	} acr_sync_state_type;

	acr_sync_state_type s_r;
	acr_sync_state_type s_nxt;

	// The first stage feeds only the second; a change counts once stages two and three agree.
	always_comb begin
		s_nxt = s_r;
		s_nxt.ff1 = pin_in;
		s_nxt.ff2 = s_r.ff1;
		s_nxt.ff3 = s_r.ff2;
		if (s_r.ff2 == s_r.ff3) begin
			s_nxt.level = s_r.ff3;
		end
	end

	// Reset to the idle high level so no false falling edge appears.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{ff1: 1'b1, ff2: 1'b1, ff3: 1'b1, level: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level_out = s_r.level;

endmodule : acr_sync
`default_nettype wire

// [acr_buf2.sv]
`default_nettype none
// ==========================================================================
// Two-entry buffer with registered outputs and honest back-pressure.
// ==========================================================================
module acr_buf2 #(
	parameter int WIDTH = acr_pkg::WORD_W
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	typedef struct packed {
		logic [WIDTH-1:0] head;
		logic head_v;
		logic [WIDTH-1:0] spare;
		logic spare_v;
	} acr_buf_state_type;

	acr_buf_state_type s_r;
	acr_buf_state_type s_nxt;
	logic in_fire;
	logic out_fire;

	assign in_fire = in_valid & ~s_r.spare_v;
	assign out_fire = s_r.head_v & out_ready;

	// Head drains first, spare refills it, then a new word lands in the free slot.
	always_comb begin
		s_nxt = s_r;
		if (out_fire) begin
			s_nxt.head_v = 1'b0;
		end
		if (!s_nxt.head_v && s_r.spare_v) begin
			s_nxt.head = s_r.spare;
			s_nxt.head_v = 1'b1;
			s_nxt.spare_v = 1'b0;
		end
		if (in_fire) begin
			if (!s_nxt.head_v) begin
				s_nxt.head = in_data;
				s_nxt.head_v = 1'b1;
			end else begin
				s_nxt.spare = in_data;
				s_nxt.spare_v = 1'b1;
			end
		end
	end

	// Register the whole buffer state.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Ready drops only when both slots hold words, so the spare is never overwritten.
	assign in_ready = ~s_r.spare_v;
	assign out_valid = s_r.head_v;
	assign out_data = s_r.head;

endmodule : acr_buf2
`default_nettype wire

// [acr_rx_recovery.sv]
// Operation
// - A high-to-low change on the receive line starts start-bit detection.
// - The first low sample after the fall counts as sample one.
// - Normal speed judges the start bit from samples eight, nine and ten.
// - Double speed judges the start bit from samples four, five and six.
// - Two or more high check samples reject the start as noise; resume watching.
// - A valid start aligns the bit phase; alignment repeats at every frame.
// - Normal speed steps sixteen sample states per bit, numbered by state.
// - Double speed steps eight sample states per bit.
// - Data and parity bits use the three centre samples, never one sample.
// - Two or three high centre samples give one, otherwise zero.
// - Recovery runs through the first stop bit; further stop bits are ignored.
// - The first stop bit uses the same three-sample majority vote.
// - A low resolved stop bit sets the frame error flag for that frame.
// - Next start edge is watched right after the last stop vote sample.
`default_nettype none
// ==========================================================================
// Receive clock and data recovery: start detection, bit voting, stop check.
// ==========================================================================
module acr_rx_recovery (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Sample rate enable, one pulse per sample from the baud divider.
	input wire logic sample_tick,
	// Serial receive pin, asynchronous to clk_sys.
	input wire logic rxd,
	// Frame format and speed.
	input wire logic double_speed_select,
	input wire logic [3:0] char_len,
	input wire logic parity_en,
	// Received word stream.
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [acr_pkg::DATA_W-1:0] rx_data,
	output logic rx_parity,
	output logic rx_frame_err,
	// Status.
	output logic frame_error_flag,
	output logic start_reject,
	output logic overrun,
	output logic busy
);

	// ======================================================================
	// State.
	// ======================================================================
	typedef struct packed {
		acr_pkg::acr_st_type st;
		logic [acr_pkg::CNT_W-1:0] cnt;
		logic rx_last;
		logic [1:0] votes;
		logic [acr_pkg::IDX_W-1:0] bit_idx;
		logic [acr_pkg::DATA_W-1:0] data;
		logic parity;
		logic fe;
		logic rej;
		logic pend;
		logic [acr_pkg::WORD_W-1:0] pend_word;
		logic ovr;
		logic busy;
	} acr_main_state_type;

	acr_main_state_type s_r;
	acr_main_state_type s_nxt;

	logic rx_s;
	logic push_ready;
	logic [3:0] char_eff;
	logic [acr_pkg::IDX_W-1:0] last_idx;
	logic [4:0] spb;
	logic [2:0] vote_set;
	logic vote_bit;
	logic at_vote;
	logic at_end;

	// ======================================================================
	// Input synchroniser.
	// ======================================================================
	// The pin runs through three synchroniser flops and the filter flop before any edge logic sees it.
	acr_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_in(rxd),
		.level_out(rx_s)
	);

	// ======================================================================
	// Decoding of format and position.
	// ======================================================================
	// Out-of-range lengths clamp to the nearest legal size rather than hang the frame.
	always_comb begin
		if (char_len < acr_pkg::CHAR_MIN) begin
			char_eff = acr_pkg::CHAR_MIN;
		end else if (char_len > acr_pkg::CHAR_MAX) begin
			char_eff = acr_pkg::CHAR_MAX;
		end else begin
			char_eff = char_len;
		end
	end

	// Index of the last data or parity bit before the stop bit.
	assign last_idx = char_eff + {3'h0, parity_en} - 4'h1;

	// Speed select sets the bit length and the vote window together.
	assign spb = acr_pkg::samples_per_bit(double_speed_select);
	assign at_vote = acr_pkg::vote_last(s_r.cnt, double_speed_select);
	assign at_end = s_r.cnt == spb;

	// The current sample joins the two earlier centre samples for the vote.
	assign vote_set = {s_r.votes, rx_s};
	assign vote_bit = acr_pkg::maj3(vote_set);

	// ======================================================================
	// Recovery state machine.
	// ======================================================================
	// Everything but the buffer hand-over advances on the sample tick only; status pulses last one clock.
	always_comb begin
		s_nxt = s_r;
		s_nxt.rej = 1'b0;
		s_nxt.ovr = 1'b0;
		// A word handed to the buffer frees the pending slot.
		if (s_r.pend && push_ready) begin
			s_nxt.pend = 1'b0;
		end
		if (sample_tick) begin
			s_nxt.rx_last = rx_s;
			if (acr_pkg::in_vote(s_r.cnt, double_speed_select) && s_r.st != acr_pkg::ACR_IDLE) begin
				s_nxt.votes = {s_r.votes[0], rx_s};
			end
			case (s_r.st)
				acr_pkg::ACR_IDLE: begin
					// Only a high-to-low change starts a frame, a held low does not.
					if (s_r.rx_last && !rx_s) begin
						s_nxt.st = acr_pkg::ACR_START;
						// The falling sample was sample one, so the counter already names the next tick's sample.
						s_nxt.cnt = acr_pkg::SAMPLE_FIRST + 5'h01;
						s_nxt.votes = 2'h0;
						s_nxt.busy = 1'b1;
					end
				end
				acr_pkg::ACR_START: begin
					s_nxt.cnt = s_r.cnt + 5'h01;
					if (at_vote && vote_bit) begin
						// Majority high means a spike, not a start bit.
						s_nxt.st = acr_pkg::ACR_IDLE;
						s_nxt.rej = 1'b1;
						s_nxt.busy = 1'b0;
					end else if (at_end) begin
						// The phase counted from the start edge now times every bit of the frame.
						s_nxt.st = acr_pkg::ACR_DATA;
						s_nxt.cnt = acr_pkg::SAMPLE_FIRST;
						s_nxt.bit_idx = 4'h0;
						s_nxt.data = '0;
						s_nxt.parity = 1'b0;
					end
				end
				acr_pkg::ACR_DATA: begin
					s_nxt.cnt = s_r.cnt + 5'h01;
					if (at_vote) begin
						if (s_r.bit_idx < char_eff) begin
							s_nxt.data[s_r.bit_idx] = vote_bit;
						end else begin
							s_nxt.parity = vote_bit;
						end
					end
					if (at_end) begin
						// Wrap after the last state of the bit, sixteen or eight.
						s_nxt.cnt = acr_pkg::SAMPLE_FIRST;
						s_nxt.bit_idx = s_r.bit_idx + 4'h1;
						if (s_r.bit_idx == last_idx) begin
							s_nxt.st = acr_pkg::ACR_STOP;
						end
					end
				end
				acr_pkg::ACR_STOP: begin
					s_nxt.cnt = s_r.cnt + 5'h01;
					if (at_vote) begin
						// The remainder of the stop bit is not waited for, so a start may follow at once.
						s_nxt.st = acr_pkg::ACR_IDLE;
						s_nxt.busy = 1'b0;
						s_nxt.fe = ~vote_bit;
						// A word still waiting for the buffer is kept; the new one is dropped.
						if (s_nxt.pend) begin
							s_nxt.ovr = 1'b1;
						end else begin
							s_nxt.pend = 1'b1;
							s_nxt.pend_word = {~vote_bit, s_r.parity, s_r.data};
						end
					end
				end
				default: begin
					s_nxt.st = acr_pkg::ACR_IDLE;
					s_nxt.busy = 1'b0;
				end
			endcase
		end
	end

	// Register the whole recovery state; the line is assumed idle high at reset.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{st: acr_pkg::ACR_IDLE, cnt: 5'h00, rx_last: 1'b1, votes: 2'h0, bit_idx: 4'h0,
				data: 9'h000, parity: 1'b0, fe: 1'b0, rej: 1'b0, pend: 1'b0, pend_word: 11'h000,
				ovr: 1'b0, busy: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ======================================================================
	// Output buffer.
	// ======================================================================
	// Two slots and the pending word absorb a receiver stall of almost three frames without loss.
	logic [acr_pkg::WORD_W-1:0] out_word;

	acr_buf2 #(
		.WIDTH(acr_pkg::WORD_W)
	) u_buf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(s_r.pend),
		.in_ready(push_ready),
		.in_data(s_r.pend_word),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(out_word)
	);

	// Word fields and status all come from flops.
	assign rx_data = out_word[acr_pkg::DATA_W-1:0];
	assign rx_parity = out_word[acr_pkg::WORD_PARITY];
	assign rx_frame_err = out_word[acr_pkg::WORD_FERR];
	assign frame_error_flag = s_r.fe;
	assign start_reject = s_r.rej;
	assign overrun = s_r.ovr;
	assign busy = s_r.busy;

	// ======================================================================
	// Checks.
	// ======================================================================
	// A falling sample in idle is sample one, so the start check goes on at sample two.
	a_start_entry: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(sample_tick && s_r.st == acr_pkg::ACR_IDLE && s_r.rx_last && !rx_s)
		|=> (s_r.st == acr_pkg::ACR_START && s_r.cnt == 5'h02)
	) else $error("start check did not count the falling sample as sample one");

	// A held low in idle never opens a frame.
	a_no_level_start: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(sample_tick && s_r.st == acr_pkg::ACR_IDLE && !s_r.rx_last)
		|=> (s_r.st == acr_pkg::ACR_IDLE)
	) else $error("frame opened without a falling edge");

	// Normal speed start vote is taken at sample ten with a high majority rejecting.
	a_start_normal: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(sample_tick && !double_speed_select && s_r.st == acr_pkg::ACR_START && s_r.cnt == 5'h0A
			&& vote_bit)
		|=> (s_r.st == acr_pkg::ACR_IDLE && start_reject)
	) else $error("normal speed start spike not rejected at sample ten");

	// Double speed start vote is taken at sample six.
	a_start_double: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(sample_tick && double_speed_select && s_r.st == acr_pkg::ACR_START && s_r.cnt == 5'h06
			&& vote_bit)
		|=> (s_r.st == acr_pkg::ACR_IDLE && start_reject)
	) else $error("double speed start spike not rejected at sample six");

	// A rejected start returns to idle in the same clock that it reports the spike.
	a_reject_idle: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(start_reject) |-> ($past(s_r.st) == acr_pkg::ACR_START && s_r.st == acr_pkg::ACR_IDLE)
	) else $error("start rejection not taken from the start check");

	// Valid start hands over to data at sample one of the first bit.
	a_start_align: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(sample_tick && s_r.st == acr_pkg::ACR_START && s_r.cnt == spb && !(at_vote && vote_bit))
		|=> (s_r.st == acr_pkg::ACR_DATA && s_r.cnt == 5'h01 && s_r.bit_idx == 4'h0)
	) else $error("data phase not aligned to the start bit");

	// Sample counter never runs past the bit length in normal speed.
	a_cnt_normal: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(!double_speed_select && s_r.st == acr_pkg::ACR_DATA) |-> (s_r.cnt >= 5'h01 && s_r.cnt <= 5'h10)
	) else $error("normal speed sample state out of range");

	// Double speed bits wrap after state eight.
	a_cnt_double: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(sample_tick && double_speed_select && s_r.st == acr_pkg::ACR_DATA && s_r.cnt == 5'h08)
		|=> (s_r.cnt == 5'h01)
	) else $error("double speed bit did not wrap after eight states");

	// A stored data bit equals the majority of its three centre samples.
	a_data_vote: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(sample_tick && s_r.st == acr_pkg::ACR_DATA && at_vote && s_r.bit_idx < char_eff)
		|=> (s_r.data[$past(s_r.bit_idx)] == $past(vote_bit))
	) else $error("data bit differs from its majority vote");

	// Stop vote sets the error flag from a low majority and frees the line watcher at once.
	a_stop_check: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(sample_tick && s_r.st == acr_pkg::ACR_STOP && at_vote)
		|=> (frame_error_flag == !$past(vote_bit) && s_r.st == acr_pkg::ACR_IDLE && !busy)
	) else $error("stop bit vote, flag or return to idle wrong");

	// The first centre sample of every bit enters the vote register at the position the speed selects.
	a_vote_window: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(sample_tick && s_r.st != acr_pkg::ACR_IDLE
			&& s_r.cnt == (double_speed_select ? acr_pkg::VOTE_FIRST_DOUBLE : acr_pkg::VOTE_FIRST_NORMAL))
		|=> (s_r.votes[0] == $past(rx_s))
	) else $error("first centre sample not taken into the vote");

	// State and sample counter never move between sample ticks.
	a_tick_only: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		!sample_tick |=> ($stable(s_r.st) && $stable(s_r.cnt))
	) else $error("recovery advanced without a sample tick");

endmodule : acr_rx_recovery
`default_nettype wire

// [acr_tx_model.sv]
`default_nettype none
// ==========================================================================
// Remote transmitter: drives the receive line one sample tick at a time.
// ==========================================================================
module acr_tx_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sample_tick,
	// Frame request: bits go out LSB first, each bit_ticks samples long except the last, which is last_ticks long.
	input wire logic send_valid,
	input wire logic [11:0] send_bits,
	input wire logic [3:0] send_len,
	input wire logic [4:0] bit_ticks,
	input wire logic [4:0] last_ticks,
	input wire logic [4:0] flip_pos,
	output logic tx_busy,
	// Serial line.
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;

	logic active = 1'b0;
	logic [11:0] bits = 12'h000;
	int len = 0;
	int last = 0;
	int flip = 0;
	int idx = 0;
	int cnt = 0;
	int nc = 0;

	assign tx_busy = active;

	// Changes land just after a tick edge, so every sample sees one settled level.
	// A flip inverts samples flip and flip+1 of a non-start bit, so a vote window one sample off misvotes.
	// Frames start only on a tick edge, so the start bit is seen for its full count of samples.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			active <= 1'b0;
			rxd <= 1'b1;
		end else if (!active) begin
			rxd <= 1'b1;
			if (send_valid && sample_tick) begin
				active <= 1'b1;
				bits <= send_bits;
				len <= int'(send_len);
				last <= int'(last_ticks);
				flip <= int'(flip_pos);
				idx <= 0;
				cnt <= 0;
				rxd <= send_bits[0];
			end
		end else if (sample_tick) begin
			nc = cnt + 1;
			if (nc == ((idx == len - 1) ? last : int'(bit_ticks))) begin
				cnt <= 0;
				if (idx == len - 1) begin
					active <= 1'b0;
					rxd <= 1'b1;
				end else begin
					idx <= idx + 1;
					rxd <= bits[idx+1];
				end
			end else begin
				cnt <= nc;
				rxd <= (idx != 0 && (nc == flip - 1 || nc == flip)) ? ~bits[idx] : bits[idx];
			end
		end
	end

endmodule : acr_tx_model
`default_nettype wire

// [async_rx_clock_data_recovery_tb_top.sv]
`default_nettype none
// ==========================================================================
// Self-checking bench with a queue model of the received words.
// ==========================================================================
module async_rx_clock_data_recovery_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys = 1'b0, rst_n = 1'b0, sample_tick = 1'b0, ds = 1'b0, pe = 1'b0;
	logic rx_ready = 1'b0, hold = 1'b0, send_valid = 1'b0;
	logic [3:0] cl = 4'h8, send_len = 4'h1;
	logic [11:0] send_bits = 12'hFFF;
	logic [4:0] bit_ticks = 5'h10, last_ticks = 5'h10, flip_pos = 5'h00;
	logic [2:0] tick_div = 3'h0;
	logic [15:0] seed = 16'h0029, rseed = 16'h0029;
	logic [10:0] e;
	wire logic rxd, tx_busy, rx_valid, rx_parity, rx_frame_err, frame_error_flag, start_reject, overrun, busy;
	wire logic [8:0] rx_data;
	int num_errors = 0, check_count = 0, rej_cnt = 0, ovr_cnt = 0, spb = 16, vf = 8, vl = 10, r0 = 0;
	logic [10:0] exp_q[$];

	acr_rx_recovery dut (.clk_sys(clk_sys), .rst_n(rst_n), .sample_tick(sample_tick), .rxd(rxd),
		.double_speed_select(ds), .char_len(cl), .parity_en(pe), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .rx_parity(rx_parity), .rx_frame_err(rx_frame_err),
		.frame_error_flag(frame_error_flag), .start_reject(start_reject), .overrun(overrun), .busy(busy));

	acr_tx_model tx_model (.clk_sys(clk_sys), .rst_n(rst_n), .sample_tick(sample_tick), .send_valid(send_valid),
		.send_bits(send_bits), .send_len(send_len), .bit_ticks(bit_ticks), .last_ticks(last_ticks),
		.flip_pos(flip_pos), .tx_busy(tx_busy), .rxd(rxd));

	// ======================================================================
	// Helpers.
	// ======================================================================
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		if (num_errors == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// Holds the request until the transmitter takes it, then waits, bounded, until the frame is done.
	task automatic tx(input logic [11:0] b, input int n, input int last, input int flip);
		int w;
		send_bits <= b;
		send_len <= 4'(n);
		last_ticks <= 5'(last);
		flip_pos <= 5'(flip);
		send_valid <= 1'b1;
		w = 0;
		do begin
			@(posedge clk_sys);
			w++;
		end while (tx_busy !== 1'b1 && w < 5000);
		send_valid <= 1'b0;
		do begin
			@(posedge clk_sys);
			w++;
		end while (tx_busy !== 1'b0 && w < 5000);
		if (w >= 5000) begin
			num_errors++;
		end
	endtask : tx

	// Builds a random character frame and records the word it should yield.
	task automatic send(input int c, input logic p, input logic stop, input int last, input int flip, input bit keep);
		logic [11:0] b;
		logic [8:0] d;
		int n;
		seed = lfsr(seed);
		d = seed[8:0] & 9'((1 << c) - 1);
		b = 12'h000;
		n = 1;
		for (int i = 0; i < c; i++) begin
			b[n] = d[i];
			n++;
		end
		if (p) begin
			b[n] = seed[15];
			n++;
		end
		b[n] = stop;
		n++;
		cl <= 4'(c);
		pe <= p;
		if (keep) begin
			exp_q.push_back({~stop, p & seed[15], d});
		end
		tx(b, n, last, flip);
		if (last == spb) begin
			repeat (2) @(posedge clk_sys);
			check("frame_error_flag", 16'(frame_error_flag), 16'(!stop));
			check("busy", 16'(busy), 16'h0000);
		end
	endtask : send

	task automatic drain();
		int w;
		w = 0;
		while (exp_q.size() != 0 && w < 3000) begin
			@(posedge clk_sys);
			w++;
		end
	endtask : drain

	// ======================================================================
	// Clock, sample ticks, random consumer and word comparison.
	// ======================================================================
	always #10 clk_sys = ~clk_sys;

	// Ticks every eighth clock leave room for the input synchroniser latency.
	always @(posedge clk_sys) begin
		tick_div <= tick_div + 3'h1;
		sample_tick <= (tick_div == 3'h7);
		rseed <= lfsr(rseed);
		rx_ready <= !hold && rseed[0];
		if (start_reject === 1'b1) rej_cnt++;
		if (overrun === 1'b1) ovr_cnt++;
		if (rst_n && rx_valid === 1'b1 && rx_ready) begin
			if (exp_q.size() == 0) begin
				check("rx_valid", 16'(rx_valid), 16'h0000);
			end else begin
				e = exp_q.pop_front();
				check("rx_data", 16'(rx_data), 16'(e[8:0]));
				check("rx_parity", 16'(rx_parity), 16'(e[9]));
				check("rx_frame_err", 16'(rx_frame_err), 16'(e[10]));
			end
		end
	end

	// ======================================================================
	// Main sequence, once per speed.
	// ======================================================================
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (40) @(posedge clk_sys);
		for (int s = 0; s < 2; s++) begin
			spb = s ? 8 : 16;
			vf = s ? 4 : 8;
			vl = s ? 6 : 10;
			ds <= 1'(s);
			bit_ticks <= 5'(spb);
			repeat (40) @(posedge clk_sys);
			r0 = rej_cnt;
			for (int g = vf - 1; g <= vf; g++) begin
				tx(12'h000, 1, g, 0);
				repeat (8 * spb) @(posedge clk_sys);
			end
			check("start_reject count", 16'(rej_cnt - r0), 16'h0002);
			for (int c = 5; c < 10; c++) begin
				for (int p = 0; p < 2; p++) begin
					send(c, 1'(p), 1'b1, spb, 0, 1);
				end
			end
			send(8, 1'b0, 1'b1, spb, vl, 1);
			send(8, 1'b1, 1'b1, spb, vf - 1, 1);
			send(6, 1'b0, 1'b0, spb, 0, 1);
			send(7, 1'b1, 1'b1, vl - 1, 0, 1);
			send(7, 1'b1, 1'b1, vl - 1, 0, 1);
			send(7, 1'b1, 1'b1, spb, 0, 1);
			drain();
			hold <= 1'b1;
			r0 = ovr_cnt;
			for (int k = 0; k < 4; k++) begin
				send(5, 1'b0, 1'b1, spb, 0, k < 3);
			end
			repeat (20) @(posedge clk_sys);
			check("overrun count", 16'(ovr_cnt - r0), 16'h0001);
			hold <= 1'b0;
			drain();
		end
		check("words left", 16'(exp_q.size()), 16'h0000);
		end_of_test();
	end

	// Watchdog sized well above the roughly thirty-six thousand clocks the tests take.
	initial begin
		repeat (90000) @(posedge clk_sys);
		num_errors++;
		end_of_test();
	end

endmodule : async_rx_clock_data_recovery_tb_top
`default_nettype wire
